// ### core/srsr_pkg.sv
package srsr_pkg;

  // ************************************************************
  // Widths and status byte layout
  // ************************************************************
  localparam int SRSR_DW   = 16;  // Command data and condition width.
  localparam int STB_QUES  = 3;   // Questionable summary bit.
  localparam int STB_MAV   = 4;   // Message available bit.
  localparam int STB_ESB   = 5;   // Standard event summary bit.
  localparam int STB_RQS   = 6;   // Request service bit.
  localparam int STB_OPER  = 7;   // Operation summary bit.

  // ************************************************************
  // Standard event latch layout and reset values
  // ************************************************************
  localparam int ESR_OPC = 0;     // Operation complete.
  localparam int ESR_DDE = 3;     // Device dependent error.
  localparam int ESR_CME = 5;     // Command error.
  localparam logic [7:0]  ESR_RST      = 8'h00;
  localparam logic [7:0]  ESE_RST      = 8'h00;
  localparam logic [7:0]  SRE_RST      = 8'h00;
  localparam logic [7:0]  SRE_USED     = 8'hbf;  // Request bit unmaskable.
  localparam logic [15:0] PTR_RST      = 16'hffff;
  localparam logic [15:0] NTR_RST      = 16'h0000;
  localparam logic [15:0] ENA_RST      = 16'h0000;
  localparam logic [15:0] EVT_RST      = 16'h0000;

  // ************************************************************
  // Reading condition codes, two's complement in three bits
  // ************************************************************
  localparam logic [2:0] CODE_STOP    = 3'h7;  // Minus one: stopped.
  localparam logic [2:0] CODE_INVALID = 3'h0;
  localparam logic [2:0] CODE_NORMAL  = 3'h1;
  localparam logic [2:0] CODE_UNDER   = 3'h2;
  localparam logic [2:0] CODE_OVER    = 3'h3;

  // ************************************************************
  // Commands and states
  // ************************************************************
  typedef enum logic [4:0] {
    OP_STB_RD       = 5'h00,
    OP_SRE_WR       = 5'h01,
    OP_SRE_RD       = 5'h02,
    OP_ESR_RD       = 5'h03,
    OP_ESE_WR       = 5'h04,
    OP_ESE_RD       = 5'h05,
    OP_CLS          = 5'h06,
    OP_RST          = 5'h07,
    OP_OPER_COND_RD = 5'h08,
    OP_OPER_EVT_RD  = 5'h09,
    OP_OPER_PTR_WR  = 5'h0a,
    OP_OPER_NTR_WR  = 5'h0b,
    OP_OPER_ENA_WR  = 5'h0c,
    OP_OPER_ENA_RD  = 5'h0d,
    OP_QUES_COND_RD = 5'h10,
    OP_QUES_EVT_RD  = 5'h11,
    OP_QUES_PTR_WR  = 5'h12,
    OP_QUES_NTR_WR  = 5'h13,
    OP_QUES_ENA_WR  = 5'h14,
    OP_QUES_ENA_RD  = 5'h15,
    OP_INIT_IMM     = 5'h18,
    OP_INIT_CONT_WR = 5'h19,
    OP_TRIG_MODE_WR = 5'h1a,
    OP_MEAS_Q       = 5'h1b,
    OP_FETCH_Q      = 5'h1c,
    OP_READ_Q       = 5'h1d
  } srsr_op_e;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CFG  = 3'b010,
    SEQ_RUN  = 3'b100
  } srsr_seq_e;

  // ************************************************************
  // Carriers and state records
  // ************************************************************
  typedef struct packed {
    srsr_op_e           op;
    logic [SRSR_DW-1:0] data;
  } srsr_cmd_s;

  typedef struct packed {
    logic [2:0]         code;
    logic [SRSR_DW-1:0] value;
  } srsr_rdg_s;

  typedef struct packed {
    logic init_imm;
    logic cont_wr;
    logic cont_val;
    logic mode_wr;
    logic mode_val;
    logic meas_q;
    logic read_q;
    logic fetch_q;
    logic abort;
  } srsr_seq_req_s;

  typedef struct packed {
    logic [SRSR_DW-1:0] cond_prev;
    logic [SRSR_DW-1:0] evt;
    logic [SRSR_DW-1:0] ptr;
    logic [SRSR_DW-1:0] ntr;
    logic [SRSR_DW-1:0] ena;
  } srsr_blk_s;

  typedef struct packed {
    srsr_seq_e st;
    logic      cont;
    logic      untriggered_repeat_mode;
    logic      pend;
    logic      meas_start;
    logic      default_cfg;
    logic      rdg_valid;
    srsr_rdg_s rdg;
    srsr_rdg_s held;
  } srsr_seq_s;

  typedef struct packed {
    logic [7:0]         standard_event_latch;
    logic [7:0]         standard_event_enable_mask;
    logic [7:0]         sre;
    logic               srq;
    logic               rsp_valid;
    logic [SRSR_DW-1:0] rsp_data;
    logic               eval_pend;
    logic               path_root;
    logic               msg_eval;
    logic               err_queue_clr;
  } srsr_main_s;

endpackage

// ### core/srsr_status_blk.sv
`timescale 1ns/1ns
module srsr_status_blk
  import srsr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic [SRSR_DW-1:0] cond,
  input  wire logic [SRSR_DW-1:0] wdata,
  input  wire logic               ptr_we,
  input  wire logic               ntr_we,
  input  wire logic               ena_we,
  input  wire logic               evt_rd,
  input  wire logic               clr,
  output logic [SRSR_DW-1:0]      evt,
  output logic [SRSR_DW-1:0]      ena,
  output logic                    summary
);

  srsr_blk_s st_ff;
  srsr_blk_s nxt_st;
  logic [SRSR_DW-1:0] hit;

  // ************************************************************
  // Edge detection, one lane per condition bit
  // ************************************************************
  // A lane latches when its selected edge is seen.
  for (genvar i = 0; i < SRSR_DW; i++) begin : g_lane
    assign hit[i] = (st_ff.ptr[i] & cond[i] & ~st_ff.cond_prev[i]) |
                    (st_ff.ntr[i] & ~cond[i] & st_ff.cond_prev[i]);
  end

  // ************************************************************
  // Next state
  // ************************************************************
  // A new edge in the clearing cycle survives the clear.
  always_comb begin
    nxt_st           = st_ff;
    nxt_st.cond_prev = cond;
    nxt_st.evt       = ((evt_rd | clr) ? EVT_RST : st_ff.evt) | hit;
    if (ptr_we) begin
      nxt_st.ptr = wdata;
    end
    if (ntr_we) begin
      nxt_st.ntr = wdata;
    end
    if (ena_we) begin
      nxt_st.ena = wdata;
    end
  end

  // Condition history resets to zero, so a bit high at release counts
  // as a rising edge.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{cond_prev: EVT_RST, evt: EVT_RST, ptr: PTR_RST,
                 ntr: NTR_RST, ena: ENA_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the registers.
  assign evt     = st_ff.evt;
  assign ena     = st_ff.ena;
  assign summary = |(st_ff.evt & st_ff.ena);

endmodule

// ### core/srsr_meas_seq.sv
`timescale 1ns/1ns
module srsr_meas_seq
  import srsr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire srsr_seq_req_s req,
  input  wire logic          trig_valid,
  input  wire logic          meas_done,
  input  wire srsr_rdg_s     meas_rdg,
  output logic               meas_start,
  output logic               default_cfg,
  output logic               rdg_valid,
  output srsr_rdg_s          rdg
);

  srsr_seq_s st_ff;
  srsr_seq_s nxt_st;
  logic      launch;

  // ************************************************************
  // Start decision
  // ************************************************************
  // Continuous mode repeats freely or waits for each trigger.
  always_comb begin
    launch = 1'b0;
    if (st_ff.st == SEQ_IDLE && !req.abort) begin
      if (st_ff.cont) begin
        launch = st_ff.untriggered_repeat_mode | trig_valid;
      end else begin
        launch = req.init_imm | req.read_q;
      end
    end
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.meas_start  = 1'b0;
    nxt_st.default_cfg = 1'b0;
    nxt_st.rdg_valid   = 1'b0;
    if (req.cont_wr) begin
      nxt_st.cont = req.cont_val;
    end
    if (req.mode_wr) begin
      nxt_st.untriggered_repeat_mode = req.mode_val;
    end
    if (req.fetch_q) begin
      nxt_st.rdg_valid = 1'b1;
      nxt_st.rdg       = st_ff.held;
    end
    if (req.read_q) begin
      nxt_st.pend = 1'b1;
    end
    case (st_ff.st)
      SEQ_IDLE: begin
        if (req.meas_q && !req.abort) begin
          nxt_st.default_cfg = 1'b1;
          nxt_st.pend        = 1'b1;
          nxt_st.st          = SEQ_CFG;
        end else if (launch) begin
          nxt_st.meas_start = 1'b1;
          nxt_st.st         = SEQ_RUN;
        end
      end
      SEQ_CFG: begin
        nxt_st.meas_start = 1'b1;
        nxt_st.st         = SEQ_RUN;
      end
      SEQ_RUN: begin
        if (meas_done) begin
          nxt_st.held = meas_rdg;
          nxt_st.st   = SEQ_IDLE;
          if (st_ff.pend) begin
            nxt_st.rdg_valid = 1'b1;
            nxt_st.rdg       = meas_rdg;
            nxt_st.pend      = 1'b0;
          end
        end
      end
      default: begin
        nxt_st.st = SEQ_IDLE;
      end
    endcase
    // Clearing the measurement stops it; held data reads as stopped.
    if (req.abort) begin
      nxt_st.st         = SEQ_IDLE;
      nxt_st.pend       = 1'b0;
      nxt_st.meas_start = 1'b0;
      nxt_st.held.code  = CODE_STOP;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{st: SEQ_IDLE, cont: 1'b0, untriggered_repeat_mode: 1'b0,
                 pend: 1'b0, meas_start: 1'b0, default_cfg: 1'b0,
                 rdg_valid: 1'b0,
                 rdg: '{code: CODE_STOP, value: '0},
                 held: '{code: CODE_STOP, value: '0}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign meas_start  = st_ff.meas_start;
  assign default_cfg = st_ff.default_cfg;
  assign rdg_valid   = st_ff.rdg_valid;
  assign rdg         = st_ff.rdg;

endmodule

// ### core/srsr_status_core.sv
// Behaviour
// - Service request mask picks which summaries may request service.
// - Status byte: message available plus three event summaries.
// - Standard event bits latch on their event until the latch is read.
// - Per-bit transition masks pick rising, falling or both edges to latch.
// - Operation block: live condition, edge masks, read-write enable.
// - Latched operation events read apart from the live condition.
// - Questionable block has the same structure as the operation block.
// - Clear status resets events, error queue, status byte, measurement.
// - Event summary is OR of standard event bits under their enable.
// - Standard event with enable requests service if status bit 5 enabled.
// - Standard event enable takes 0 to 255; writing zero clears it.
// - Standard event enable survives clear, reset and device clear.
// - Reading the standard event latch returns it, then clears it.
// - Bits 0, 3, 5 used: complete, device error, command error.
// - Reading condition code: stopped, invalid, normal, under, over.
// - Continuous off: one measurement per immediate initiate command.
// - Continuous on: free run repeats, else one cycle per trigger.
// - Measure query applies defaults then runs one complete measurement.
// - Fetch returns held data; read returns a freshly acquired measurement.
// - Status byte readable; service request mask writable and readable.
// - On message end, reset command path to root, then evaluate.
`timescale 1ns/1ns
module srsr_status_core
  import srsr_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               cmd_valid,
  input  wire srsr_cmd_s          cmd,
  output logic                    rsp_valid,
  output logic [SRSR_DW-1:0]      rsp_data,
  input  wire logic               mav,
  input  wire logic               opc_evt,
  input  wire logic               dev_err_evt,
  input  wire logic               cmd_err_evt,
  input  wire logic [SRSR_DW-1:0] oper_cond,
  input  wire logic [SRSR_DW-1:0] ques_cond,
  input  wire logic               msg_end,
  input  wire logic               trig_valid,
  input  wire logic               meas_done,
  input  wire srsr_rdg_s          meas_rdg,
  output logic                    srq,
  output logic                    path_root,
  output logic                    msg_eval,
  output logic                    err_queue_clr,
  output logic                    meas_start,
  output logic                    default_cfg,
  output logic                    rdg_valid,
  output srsr_rdg_s               rdg
);

  // ************************************************************
  // Declarations
  // ************************************************************
  srsr_main_s         st_ff;
  srsr_main_s         nxt_st;
  srsr_seq_req_s      seq_req;
  logic               cls;
  logic               rst_cmd;
  logic [SRSR_DW-1:0] oper_evt;
  logic [SRSR_DW-1:0] oper_ena;
  logic [SRSR_DW-1:0] ques_evt;
  logic [SRSR_DW-1:0] ques_ena;
  logic               oper_sum;
  logic               ques_sum;
  logic               esb;
  logic [7:0]         esr_set;
  logic [7:0]         stb;

  // ************************************************************
  // Command decode
  // ************************************************************
  // Every strobe is gated by the command valid, so an idle port is inert.
  function automatic logic is_op(input srsr_op_e op);
    is_op = cmd_valid && (cmd.op == op);
  endfunction

  // Continuous decodes name the command directly: a function call here
  // would only be re-evaluated when its constant argument changes.
  assign cls     = cmd_valid && (cmd.op == OP_CLS);
  assign rst_cmd = cmd_valid && (cmd.op == OP_RST);

  // ************************************************************
  // Operation and questionable blocks
  // ************************************************************
  // Both blocks are the same module, so their behaviour cannot drift.
  srsr_status_blk u_oper (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cond    (oper_cond),
    .wdata   (cmd.data),
    .ptr_we  (cmd_valid && (cmd.op == OP_OPER_PTR_WR)),
    .ntr_we  (cmd_valid && (cmd.op == OP_OPER_NTR_WR)),
    .ena_we  (cmd_valid && (cmd.op == OP_OPER_ENA_WR)),
    .evt_rd  (cmd_valid && (cmd.op == OP_OPER_EVT_RD)),
    .clr     (cls),
    .evt     (oper_evt),
    .ena     (oper_ena),
    .summary (oper_sum)
  );

  // The questionable block reuses the operation block unchanged.
  srsr_status_blk u_ques (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cond    (ques_cond),
    .wdata   (cmd.data),
    .ptr_we  (cmd_valid && (cmd.op == OP_QUES_PTR_WR)),
    .ntr_we  (cmd_valid && (cmd.op == OP_QUES_NTR_WR)),
    .ena_we  (cmd_valid && (cmd.op == OP_QUES_ENA_WR)),
    .evt_rd  (cmd_valid && (cmd.op == OP_QUES_EVT_RD)),
    .clr     (cls),
    .evt     (ques_evt),
    .ena     (ques_ena),
    .summary (ques_sum)
  );

  // ************************************************************
  // Measurement sequencer
  // ************************************************************
  // A reset command stops measuring just as clear status does.
  always_comb begin
    seq_req.init_imm = is_op(OP_INIT_IMM);
    seq_req.cont_wr  = is_op(OP_INIT_CONT_WR);
    seq_req.cont_val = cmd.data[0];
    seq_req.mode_wr  = is_op(OP_TRIG_MODE_WR);
    seq_req.mode_val = cmd.data[0];
    seq_req.meas_q   = is_op(OP_MEAS_Q);
    seq_req.read_q   = is_op(OP_READ_Q);
    seq_req.fetch_q  = is_op(OP_FETCH_Q);
    seq_req.abort    = cls | rst_cmd;
  end

  srsr_meas_seq u_seq (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .req         (seq_req),
    .trig_valid  (trig_valid),
    .meas_done   (meas_done),
    .meas_rdg    (meas_rdg),
    .meas_start  (meas_start),
    .default_cfg (default_cfg),
    .rdg_valid   (rdg_valid),
    .rdg         (rdg)
  );

  // ************************************************************
  // Status byte
  // ************************************************************
  // Summaries are live ORs, so clearing the sources clears the byte.
  always_comb begin
    esr_set          = 8'h00;
    esr_set[ESR_OPC] = opc_evt;
    esr_set[ESR_DDE] = dev_err_evt;
    esr_set[ESR_CME] = cmd_err_evt;
    esb = |(st_ff.standard_event_latch &
            st_ff.standard_event_enable_mask);
    stb           = 8'h00;
    stb[STB_QUES] = ques_sum;
    stb[STB_MAV]  = mav;
    stb[STB_ESB]  = esb;
    stb[STB_OPER] = oper_sum;
    stb[STB_RQS]  = st_ff.srq;
  end

  // ************************************************************
  // Register state and answers
  // ************************************************************
  always_comb begin
    nxt_st               = st_ff;
    nxt_st.rsp_valid     = 1'b0;
    nxt_st.path_root     = 1'b0;
    nxt_st.msg_eval      = 1'b0;
    nxt_st.err_queue_clr = cls | rst_cmd;
    // Events set after any clear in the same cycle, so none is lost.
    nxt_st.standard_event_latch =
      ((is_op(OP_ESR_RD) | cls) ? ESR_RST : st_ff.standard_event_latch)
      | esr_set;
    // Request level follows enabled summaries; the request bit is excluded.
    nxt_st.srq = |(stb & st_ff.sre & SRE_USED);
    // Message end first returns the path to root, then hands over.
    if (msg_end) begin
      nxt_st.path_root = 1'b1;
      nxt_st.eval_pend = 1'b1;
    end
    if (st_ff.eval_pend) begin
      nxt_st.msg_eval  = 1'b1;
      nxt_st.eval_pend = msg_end;
    end
    if (cmd_valid) begin
      case (cmd.op)
        OP_STB_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, stb};
        end
        OP_SRE_WR: begin
          nxt_st.sre = cmd.data[7:0] & SRE_USED;
        end
        OP_SRE_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, st_ff.sre};
        end
        OP_ESR_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, st_ff.standard_event_latch};
        end
        OP_ESE_WR: begin
          // Eight bits hold every legal value; upper data bits are dropped.
          nxt_st.standard_event_enable_mask = cmd.data[7:0];
        end
        OP_ESE_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = {8'h00, st_ff.standard_event_enable_mask};
        end
        OP_OPER_COND_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = oper_cond;
        end
        OP_OPER_EVT_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = oper_evt;
        end
        OP_OPER_ENA_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = oper_ena;
        end
        OP_QUES_COND_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = ques_cond;
        end
        OP_QUES_EVT_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = ques_evt;
        end
        OP_QUES_ENA_RD: begin
          nxt_st.rsp_valid = 1'b1;
          nxt_st.rsp_data  = ques_ena;
        end
        default: begin
          // Clear status and reset never touch the enable masks.
          nxt_st.rsp_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_ff <= '{standard_event_latch: ESR_RST,
                 standard_event_enable_mask: ESE_RST,
                 sre: SRE_RST, srq: 1'b0, rsp_valid: 1'b0,
                 rsp_data: '0, eval_pend: 1'b0, path_root: 1'b0,
                 msg_eval: 1'b0, err_queue_clr: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign rsp_valid     = st_ff.rsp_valid;
  assign rsp_data      = st_ff.rsp_data;
  assign srq           = st_ff.srq;
  assign path_root     = st_ff.path_root;
  assign msg_eval      = st_ff.msg_eval;
  assign err_queue_clr = st_ff.err_queue_clr;

endmodule

// ### verif/srsr_status_core_properties.sv
`timescale 1ns/1ns
module srsr_status_core_properties
  import srsr_pkg::*;
(
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic               cmd_valid,
  input wire srsr_cmd_s          cmd,
  input wire logic               rsp_valid,
  input wire logic [SRSR_DW-1:0] rsp_data,
  input wire logic               msg_end,
  input wire logic               path_root,
  input wire logic               msg_eval,
  input wire logic               err_queue_clr,
  input wire logic               default_cfg,
  input wire logic               meas_start,
  input wire logic               rdg_valid,
  input wire logic               srq
);
  // ************************************************************
  // Port timing checks, all in the single clock domain.
  // ************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Each answer is tied to the command taken one edge earlier.
  AST_ESE_ANSWER: assert property (cmd_valid && cmd.op == OP_ESE_RD
    |=> rsp_valid)
    else $error("mask read gave no answer");
  AST_ESR_UNUSED: assert property (cmd_valid && cmd.op == OP_ESR_RD |=>
    rsp_data[7:6] == 2'b00 && !rsp_data[4] && rsp_data[15:8] == 8'h00)
    else $error("unused latch bits read high");
  AST_WR_QUIET: assert property (cmd_valid && cmd.op == OP_ESE_WR
    |=> !rsp_valid)
    else $error("mask write answered");
  AST_STB_LOW: assert property (cmd_valid && cmd.op == OP_STB_RD |=>
    rsp_valid && rsp_data[2:0] == 3'h0)
    else $error("status byte low bits set");
  AST_SRE_RQS: assert property (cmd_valid && cmd.op == OP_SRE_RD
    |=> !rsp_data[6])
    else $error("request bit shown in mask");
  AST_PATH_ORDER: assert property (msg_end |=> path_root ##1 msg_eval)
    else $error("terminator order wrong");
  AST_CLS_QUEUE: assert property (cmd_valid && cmd.op == OP_CLS
    |=> err_queue_clr)
    else $error("error queue not cleared");
  // A clear or reset in the configure cycle rightly cancels the start.
  AST_CFG_START: assert property (default_cfg &&
    !(cmd_valid && (cmd.op == OP_CLS || cmd.op == OP_RST)) |=> meas_start)
    else $error("no start after defaults");
  AST_FETCH_ANS: assert property (cmd_valid && cmd.op == OP_FETCH_Q
    |=> rdg_valid)
    else $error("fetch gave no reading");

  C_ESR: cover property (cmd_valid && cmd.op == OP_ESR_RD);
  C_SRQ: cover property ($rose(srq));
  C_RDG: cover property (rdg_valid);
endmodule
bind srsr_status_core srsr_status_core_properties srsr_status_core_properties_i (
  .clk, .sys_rst, .cmd_valid, .cmd, .rsp_valid, .rsp_data, .msg_end,
  .path_root, .msg_eval, .err_queue_clr, .default_cfg, .meas_start,
  .rdg_valid, .srq);

// ### verif/srsr_host_model.sv
`timescale 1ns/1ns
module srsr_host_model
  import srsr_pkg::*;
(
  input  wire logic clk,
  output logic      cmd_valid,
  output srsr_cmd_s cmd
);
  // Idle until the first command.
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // One command held across one taking edge; released data is inverted so a
  // stale value can never pass for a fresh one.
  task automatic send(input srsr_op_e op, input logic [15:0] d);
    @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd = '{op, d};
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    cmd = '{op, ~d};
  endtask
endmodule

// ### verif/srsr_status_core_bench.sv
`timescale 1ns/1ns
module srsr_status_core_bench
  import srsr_pkg::*;
;
  typedef struct packed {
    srsr_op_e    op;
    logic [15:0] d;
    logic        ans;
    logic [15:0] exp;
  } srsr_row_s;
  logic clk = 0, sys_rst = 1, mav = 0, opc_evt = 0, dev_err_evt = 0;
  logic cmd_err_evt = 0, msg_end = 0, meas_done = 0, trig_valid = 0;
  logic [15:0] oper_cond = 0, ques_cond = 0;
  srsr_rdg_s meas_rdg = '0;
  logic cmd_valid, rsp_valid, srq, path_root, msg_eval, err_queue_clr;
  logic meas_start, default_cfg, rdg_valid;
  logic [15:0] rsp_data;
  srsr_cmd_s cmd;
  srsr_rdg_s rdg;
  int err_count = 0, checks = 0;
  localparam srsr_row_s ROWS [8] = '{
    '{OP_ESE_WR, 16'h0029, 1'b0, 16'h0000},
    '{OP_ESE_RD, 16'h0000, 1'b1, 16'h0029},
    '{OP_SRE_WR, 16'hffff, 1'b0, 16'h0000},
    '{OP_SRE_RD, 16'h0000, 1'b1, 16'h00bf},
    '{OP_ESE_WR, 16'h00ff, 1'b0, 16'h0000},
    '{OP_ESE_RD, 16'h0000, 1'b1, 16'h00ff},
    '{OP_ESE_WR, 16'h0000, 1'b0, 16'h0000},
    '{OP_ESE_RD, 16'h0000, 1'b1, 16'h0000}};

  // ************************************************************
  // Clock, design and host
  // ************************************************************
  always #50 clk = ~clk;
  srsr_host_model srsr_host_model_i (.clk, .cmd_valid, .cmd);
  srsr_status_core srsr_status_core_i (.clk, .sys_rst, .cmd_valid, .cmd,
    .rsp_valid, .rsp_data, .mav, .opc_evt, .dev_err_evt, .cmd_err_evt,
    .oper_cond, .ques_cond, .msg_end, .trig_valid, .meas_done,
    .meas_rdg, .srq, .path_root, .msg_eval, .err_queue_clr, .meas_start,
    .default_cfg, .rdg_valid, .rdg);

  // Compare four-state values so an unknown never matches.
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Starts a measurement and returns a reading with the given code.
  task automatic run(input srsr_op_e op, input logic [2:0] code);
    srsr_host_model_i.send(op, 16'h0000);
    if (op == OP_MEAS_Q) begin
      chk(default_cfg, 1'b1);
      @(posedge clk) #1;
    end
    chk(meas_start, 1'b1);
    @(posedge clk) #1;
    meas_done = 1'b1;
    meas_rdg = '{code, 16'h1230};
    @(posedge clk) #1;
    meas_done = 1'b0;
    meas_rdg = '{~code, 16'hedcf};
    if (op != OP_INIT_IMM) chk(rdg, {code, 16'h1230});
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: table rows first, then the awkward cases.
  initial begin
    logic [4:0] base;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk(srq, 1'b0);
    chk(rdg, {CODE_STOP, 16'h0000});
    foreach (ROWS[i]) begin
      srsr_host_model_i.send(ROWS[i].op, ROWS[i].d);
      chk(rsp_valid, ROWS[i].ans);
      if (ROWS[i].ans) chk(rsp_data, ROWS[i].exp);
    end
    for (int b = 0; b < 2; b++) begin
      base = b ? 5'h10 : 5'h08;
      srsr_host_model_i.send(srsr_op_e'(base + 5'h2), 16'h0001);
      srsr_host_model_i.send(srsr_op_e'(base + 5'h3), 16'h0002);
      if (b) ques_cond = 16'h0003; else oper_cond = 16'h0003;
      srsr_host_model_i.send(srsr_op_e'(base + 5'h1), 16'h0000);
      chk(rsp_data, 16'h0001);
      srsr_host_model_i.send(srsr_op_e'(base), 16'h0000);
      chk(rsp_data, 16'h0003);
      if (b) ques_cond = 16'h0000; else oper_cond = 16'h0000;
      srsr_host_model_i.send(srsr_op_e'(base + 5'h1), 16'h0000);
      chk(rsp_data, 16'h0002);
    end
    {opc_evt, dev_err_evt, cmd_err_evt} = 3'b111;
    @(posedge clk) #1 {opc_evt, dev_err_evt, cmd_err_evt} = 3'b000;
    srsr_host_model_i.send(OP_ESE_WR, 16'h0020);
    srsr_host_model_i.send(OP_SRE_WR, 16'h0020);
    srsr_host_model_i.send(OP_STB_RD, 16'h0000);
    chk(rsp_data, 16'h0060);
    chk(srq, 1'b1);
    srsr_host_model_i.send(OP_ESR_RD, 16'h0000);
    chk(rsp_data, 16'h0029);
    srsr_host_model_i.send(OP_ESR_RD, 16'h0000);
    chk(rsp_data, 16'h0000);
    chk(srq, 1'b0);
    opc_evt = 1'b1;
    @(posedge clk) #1 opc_evt = 1'b0;
    srsr_host_model_i.send(OP_CLS, 16'h0000);
    chk(err_queue_clr, 1'b1);
    srsr_host_model_i.send(OP_ESR_RD, 16'h0000);
    chk(rsp_data, 16'h0000);
    srsr_host_model_i.send(OP_RST, 16'h0000);
    srsr_host_model_i.send(OP_ESE_RD, 16'h0000);
    chk(rsp_data, 16'h0020);
    run(OP_INIT_IMM, CODE_INVALID);
    run(OP_MEAS_Q, CODE_OVER);
    run(OP_READ_Q, CODE_NORMAL);
    run(OP_READ_Q, CODE_UNDER);
    srsr_host_model_i.send(OP_FETCH_Q, 16'h0000);
    chk(rdg_valid, 1'b1);
    chk(rdg, {CODE_UNDER, 16'h1230});
    // Continuous on: one start per trigger, then free run starts unasked.
    srsr_host_model_i.send(OP_INIT_CONT_WR, 16'h0001);
    trig_valid = 1'b1;
    @(posedge clk) #1 trig_valid = 1'b0;
    chk(meas_start, 1'b1);
    meas_done = 1'b1;
    @(posedge clk) #1 meas_done = 1'b0;
    srsr_host_model_i.send(OP_TRIG_MODE_WR, 16'h0001);
    chk(meas_start, 1'b0);
    @(posedge clk) #1 chk(meas_start, 1'b1);
    msg_end = 1'b1;
    @(posedge clk) #1 msg_end = 1'b0;
    chk(path_root, 1'b1);
    @(posedge clk) #1 chk(msg_eval, 1'b1);
    conclude();
  end
endmodule
